//--- urisc_defines.svh
// constants for the uart reset, interrupt and sleep housekeeping block
// How it works
// - pin, power-on and software reset act alike
// - reset clears control registers and fifo pointers
// - line control resets to 0x1d
// - ident bit0 set; line status bits 5,6 set
// - modem status low nibble cleared; tx level 0x40
// - divisor, scratch, flow characters survive reset
// - tx and rts high, io inputs, irq released
// - enables gate sources; idle code 0x01
// - line status 0x06; rx time-out 0x0c
// - receive data ready code 0x04
// - transmit holding empty code 0x02
// - modem change 0x00; io change 0x30
// - stop/special char 0x10; rts/cts rise 0x20
// - line status bit7 while any fifo error
// - error bits follow fifo head, zero empty
// - resume char clears stop irq; ident read clears special char irq
// - irq mode when enable bits 3:0 nonzero
// - sleep needs enhanced bit and sleep enable
// - sleep only when fully idle
// - sleep stops clock; wake on activity
// - time-out four characters after last
// - break detect; break send holds tx low
`ifndef URISC_DEFINES_SVH
`define URISC_DEFINES_SVH
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define URISC_LCTL_RST 8'h1d
`define URISC_IDENT_RST 8'h01
`define URISC_LSTAT_RST 8'h60
`define URISC_TXFL_RST 8'h40
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define URISC_IEN_SLEEP 4
`define URISC_IEN_XOFF 5
`define URISC_IEN_RTSCTS 7
`define URISC_ENHF_ON 4
`define URISC_LCTL_BREAK 6
`define URISC_FIFO_EN 0
// ----------------------------------------------------------------
// identification codes
// ----------------------------------------------------------------
`define URISC_ID_NONE 6'h01
`define URISC_ID_LSTAT 6'h06
`define URISC_ID_RXTO 6'h0c
`define URISC_ID_RXD 6'h04
`define URISC_ID_TXE 6'h02
`define URISC_ID_MDM 6'h00
`define URISC_ID_IO 6'h30
`define URISC_ID_XOFF 6'h10
`define URISC_ID_RTSCTS 6'h20
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define URISC_TO_CHARS 4
`endif

//--- urisc_pkg.sv
// types for the uart reset, interrupt and sleep housekeeping block
package urisc_pkg;
    // power state
    typedef enum logic [1:0] {
        URISC_AWAKE = 2'b00,
        URISC_SLEEP = 2'b01
    } urisc_pwr_t;
endpackage

//--- urisc_err_track.sv
// counter of errored characters held in the receive fifo
`timescale 1ns/1ps
module urisc_err_track #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // fifo events
    input wire logic push,
    input wire logic push_err,
    input wire logic pop,
    input wire logic pop_err,
    // result
    output logic any_err
);
    localparam int W = $clog2(DEPTH + 1);
    initial begin
        if (DEPTH < 1) $error("depth must be positive");
    end
    typedef struct packed {
        logic [W-1:0] cnt;
        logic any;
    } urisc_et_t;
    urisc_et_t st_ff, nxt_st;
    // count errored entries; flag while nonzero
    always_comb begin
        nxt_st = st_ff;
        if (push && push_err && !(pop && pop_err)) begin
            nxt_st.cnt = st_ff.cnt + W'(1);
        end else if (!(push && push_err) && pop && pop_err && st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - W'(1);
        end
        nxt_st.any = (nxt_st.cnt != '0);
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign any_err = st_ff.any;
endmodule

//--- urisc_ctrl.sv
// uart reset values, interrupt priority and sleep control
`timescale 1ns/1ps
`include "urisc_defines.svh"
module urisc_ctrl #(
    parameter int FIFO_DEPTH = 64,
    parameter int CHAR_CYC_W = 16
) (
    // clock and resets
    core_clk,
    srst,
    soft_rst,
    // control registers written by host
    irq_enable_reg,
    fifo_ctrl_reg,
    line_ctrl_wr,
    line_ctrl_wdata,
    enhanced_feature_reg,
    io_irq_enable_reg,
    // receive side events
    rx_push,
    rx_push_err,
    rx_pop,
    rx_head_err,
    rx_fifo_level,
    rx_trig_hit,
    rx_stop_centre,
    rx_line,
    char_cycles,
    // transmit side
    tx_fifo_empty,
    tx_shift_empty,
    tx_trig_hit,
    tx_write,
    tx_data_bit,
    // other sources
    modem_in,
    io_change,
    stop_char_seen,
    resume_char_seen,
    special_char_seen,
    rts_cts_rise,
    irq_ident_rd,
    // outputs
    irq_ident_reg,
    line_status_reg,
    modem_status_reg,
    line_ctrl_reg,
    tx_fifo_level,
    irq_n,
    tx_pin,
    rts_n,
    io_oe,
    uart_clk_en,
    sleeping
);
    // clock and resets
    input wire logic core_clk;
    input wire logic srst;
    input wire logic soft_rst;
    // control registers
    input wire logic [7:0] irq_enable_reg;
    input wire logic [7:0] fifo_ctrl_reg;
    input wire logic line_ctrl_wr;
    input wire logic [7:0] line_ctrl_wdata;
    input wire logic [7:0] enhanced_feature_reg;
    input wire logic [7:0] io_irq_enable_reg;
    // receive side
    input wire logic rx_push;
    input wire logic [2:0] rx_push_err;
    input wire logic rx_pop;
    input wire logic [2:0] rx_head_err;
    input wire logic [6:0] rx_fifo_level;
    input wire logic rx_trig_hit;
    input wire logic rx_stop_centre;
    input wire logic rx_line;
    input wire logic [CHAR_CYC_W-1:0] char_cycles;
    // transmit side
    input wire logic tx_fifo_empty;
    input wire logic tx_shift_empty;
    input wire logic tx_trig_hit;
    input wire logic tx_write;
    input wire logic tx_data_bit;
    // other sources
    input wire logic [3:0] modem_in;
    input wire logic io_change;
    input wire logic stop_char_seen;
    input wire logic resume_char_seen;
    input wire logic special_char_seen;
    input wire logic rts_cts_rise;
    input wire logic irq_ident_rd;
    // outputs
    output logic [7:0] irq_ident_reg;
    output logic [7:0] line_status_reg;
    output logic [7:0] modem_status_reg;
    output logic [7:0] line_ctrl_reg;
    output logic [7:0] tx_fifo_level;
    output logic irq_n;
    output logic tx_pin;
    output logic rts_n;
    output logic io_oe;
    output logic uart_clk_en;
    output logic sleeping;
    initial begin
        if (FIFO_DEPTH != 64) $error("level registers assume a 64 entry fifo");
        if (CHAR_CYC_W < 4) $error("character counter too narrow");
    end
    localparam int TO_W = CHAR_CYC_W + 3;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] lctl;
        logic [7:0] ident;
        logic [7:0] lstat;
        logic [3:0] mdm_delta;
        logic [3:0] modem_prev;
        logic txe_pend;
        logic xoff_pend;
        logic special_pend;
        logic io_pend;
        logic rtscts_pend;
        logic to_pend;
        logic [TO_W-1:0] to_cnt;
        logic [TO_W-1:0] brk_cnt;
        logic brk_seen;
        urisc_pkg::urisc_pwr_t pwr;
        logic irq_n;
        logic tx_pin;
        logic rts_n;
        logic io_oe;
        logic clk_en;
    } urisc_st_t;
    urisc_st_t st_ff, nxt_st;

    // any reset source, all handled identically
    logic any_rst;
    // any errored entry held in the fifo
    logic fifo_err;

    assign any_rst = srst | soft_rst;

    urisc_err_track #(
        .DEPTH(FIFO_DEPTH)
    ) u_err (
        .core_clk(core_clk),
        .srst(any_rst),
        .push(rx_push),
        .push_err(|rx_push_err),
        .pop(rx_pop),
        .pop_err(|rx_head_err),
        .any_err(fifo_err)
    );

    // interrupt sources after enable gating
    logic fifo_en, src_lst, src_to, src_rxd, src_txe, src_mdm, src_io, src_xoff, src_rc;
    logic [5:0] id_code;
    logic irq_mode, sleep_ok, wake, rx_empty;

    always_comb begin
        fifo_en = fifo_ctrl_reg[`URISC_FIFO_EN];
        rx_empty = (rx_fifo_level == 7'h00);
        src_lst = irq_enable_reg[2] & (st_ff.lstat[7] | st_ff.lstat[1]);
        src_to = irq_enable_reg[0] & st_ff.to_pend;
        src_rxd = irq_enable_reg[0] & (fifo_en ? rx_trig_hit : !rx_empty);
        src_txe = irq_enable_reg[1] & st_ff.txe_pend;
        src_mdm = irq_enable_reg[3] & (|st_ff.mdm_delta);
        src_io = (|io_irq_enable_reg) & st_ff.io_pend;
        src_xoff = irq_enable_reg[`URISC_IEN_XOFF] & (st_ff.xoff_pend | st_ff.special_pend);
        src_rc = irq_enable_reg[`URISC_IEN_RTSCTS] & st_ff.rtscts_pend;
        if (src_lst) begin
            id_code = `URISC_ID_LSTAT;
        end else if (src_to) begin
            id_code = `URISC_ID_RXTO;
        end else if (src_rxd) begin
            id_code = `URISC_ID_RXD;
        end else if (src_txe) begin
            id_code = `URISC_ID_TXE;
        end else if (src_mdm) begin
            id_code = `URISC_ID_MDM;
        end else if (src_io) begin
            id_code = `URISC_ID_IO;
        end else if (src_xoff) begin
            id_code = `URISC_ID_XOFF;
        end else if (src_rc) begin
            id_code = `URISC_ID_RTSCTS;
        end else begin
            id_code = `URISC_ID_NONE;
        end
        // polled mode keeps irq quiet for uart sources except io, stop/special and rts/cts
        irq_mode = |irq_enable_reg[3:0];
        // permission and idle; a lower source hidden behind transmit-empty still blocks
        sleep_ok = enhanced_feature_reg[`URISC_ENHF_ON] & irq_enable_reg[`URISC_IEN_SLEEP]
                   & rx_line & tx_fifo_empty & tx_shift_empty & rx_empty
                   & !(src_lst | src_to | src_rxd | src_mdm | src_io | src_xoff | src_rc);
        wake = !rx_line | (modem_in != st_ff.modem_prev) | tx_write;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.modem_prev = modem_in;
        // line control write
        if (line_ctrl_wr) begin
            nxt_st.lctl = line_ctrl_wdata;
        end
        // modem deltas: set wins over nothing, cleared only by reset here
        nxt_st.mdm_delta = st_ff.mdm_delta | (modem_in ^ st_ff.modem_prev);
        // transmit empty pending follows mode
        nxt_st.txe_pend = fifo_en ? tx_trig_hit : tx_fifo_empty;
        if (io_change) begin
            nxt_st.io_pend = 1'b1;
        end
        if (rts_cts_rise) begin
            nxt_st.rtscts_pend = 1'b1;
        end
        // special cleared by ident read, set wins
        if (irq_ident_rd) begin
            nxt_st.special_pend = 1'b0;
            nxt_st.io_pend = io_change;
            nxt_st.rtscts_pend = rts_cts_rise;
        end
        if (special_char_seen) begin
            nxt_st.special_pend = 1'b1;
        end
        // stop interrupt cleared by resume char
        if (resume_char_seen) begin
            nxt_st.xoff_pend = 1'b0;
        end
        if (stop_char_seen) begin
            nxt_st.xoff_pend = 1'b1;
        end
        if (rx_stop_centre || rx_pop || rx_empty || rx_trig_hit) begin
            nxt_st.to_cnt = '0;
            nxt_st.to_pend = !(rx_empty || rx_pop) & st_ff.to_pend & !rx_stop_centre;
        end else if (st_ff.to_cnt < TO_W'(`URISC_TO_CHARS) * TO_W'(char_cycles)) begin
            nxt_st.to_cnt = st_ff.to_cnt + TO_W'(1);
        end else begin
            nxt_st.to_pend = 1'b1;
        end
        // break detect when line low beyond a character
        if (rx_line) begin
            nxt_st.brk_cnt = '0;
            nxt_st.brk_seen = 1'b0;
        end else if (st_ff.brk_cnt <= TO_W'(char_cycles)) begin
            nxt_st.brk_cnt = st_ff.brk_cnt + TO_W'(1);
        end else begin
            nxt_st.brk_seen = 1'b1;
        end
        // head error bits, zero when empty
        nxt_st.lstat[4:2] = rx_empty ? 3'b000 : rx_head_err;
        if (st_ff.brk_seen & !rx_empty) begin
            nxt_st.lstat[4] = 1'b1;
        end
        nxt_st.lstat[7] = fifo_err;
        nxt_st.lstat[0] = !rx_empty;
        nxt_st.lstat[5] = tx_fifo_empty;
        nxt_st.lstat[6] = tx_fifo_empty & tx_shift_empty;
        // identification register with fifo flags
        nxt_st.ident = {fifo_en, fifo_en, id_code};
        // irq asserted while enabled source pending
        nxt_st.irq_n = !((id_code != `URISC_ID_NONE) &&
                         (irq_mode || src_io || src_xoff || src_rc));
        nxt_st.tx_pin = st_ff.lctl[`URISC_LCTL_BREAK] ? 1'b0 : tx_data_bit;
        case (st_ff.pwr)
            urisc_pkg::URISC_AWAKE: begin
                if (sleep_ok && !wake) begin
                    nxt_st.pwr = urisc_pkg::URISC_SLEEP;
                    nxt_st.clk_en = 1'b0;
                end else begin
                    nxt_st.clk_en = 1'b1;
                end
            end
            urisc_pkg::URISC_SLEEP: begin
                if (wake || !sleep_ok) begin
                    nxt_st.pwr = urisc_pkg::URISC_AWAKE;
                    nxt_st.clk_en = 1'b1;
                end
            end
            default: begin
                nxt_st.pwr = urisc_pkg::URISC_AWAKE;
                nxt_st.clk_en = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers; divisor, scratch and flow chars live elsewhere
    // ----------------------------------------------------------------
    // reset clears control state
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            st_ff <= '0;
            st_ff.lctl <= `URISC_LCTL_RST;
            st_ff.ident <= `URISC_IDENT_RST;
            st_ff.lstat <= `URISC_LSTAT_RST;
            st_ff.modem_prev <= modem_in; // pins idling high raise no false delta
            st_ff.irq_n <= 1'b1;
            st_ff.tx_pin <= 1'b1;
            st_ff.rts_n <= 1'b1;
            st_ff.io_oe <= 1'b0;
            st_ff.clk_en <= 1'b1;
            st_ff.pwr <= urisc_pkg::URISC_AWAKE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // divisor, scratch and flow chars are not here
    assign irq_ident_reg = st_ff.ident;
    assign line_status_reg = st_ff.lstat;
    assign modem_status_reg = {~st_ff.modem_prev, st_ff.mdm_delta};
    assign line_ctrl_reg = st_ff.lctl;
    assign tx_fifo_level = `URISC_TXFL_RST;
    assign irq_n = st_ff.irq_n;
    assign tx_pin = st_ff.tx_pin;
    assign rts_n = st_ff.rts_n;
    assign io_oe = st_ff.io_oe;
    assign uart_clk_en = st_ff.clk_en;
    assign sleeping = (st_ff.pwr == urisc_pkg::URISC_SLEEP);
endmodule

//--- urisc_ctrl_sva.sv
// concurrent checks on the housekeeping block ports
`timescale 1ns/1ps
module urisc_chk (
    // clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic soft_rst,
    // watched inputs
    input wire logic [7:0] irq_enable_reg,
    input wire logic [7:0] enhanced_feature_reg,
    input wire logic [6:0] rx_fifo_level,
    input wire logic tx_write,
    // watched outputs
    input wire logic [7:0] irq_ident_reg,
    input wire logic [7:0] line_status_reg,
    input wire logic [7:0] line_ctrl_reg,
    input wire logic [7:0] tx_fifo_level,
    input wire logic irq_n,
    input wire logic tx_pin,
    input wire logic rts_n,
    input wire logic io_oe,
    input wire logic uart_clk_en,
    input wire logic sleeping
);
    // ----------------------------------------
    // one domain, hardware reset disables all
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_soft_rst_regs: assert property (soft_rst |=> line_ctrl_reg == 8'h1d && irq_ident_reg == 8'h01
        && line_status_reg == 8'h60) else $error("soft reset register values wrong");
    a_soft_rst_pins: assert property (soft_rst |=> irq_n && tx_pin && rts_n && !io_oe)
        else $error("soft reset pin states wrong");
    a_tx_fifo_level_const: assert property (tx_fifo_level == 8'h40) else $error("tx level not 0x40");
    // request line and code leave the same edge, so an asserted line always shows a code
    a_irq_with_code: assert property (!irq_n |-> !irq_ident_reg[0])
        else $error("irq asserted with idle code");
    a_break_send: assert property (line_ctrl_reg[6] && $past(line_ctrl_reg[6]) |-> !tx_pin)
        else $error("tx not held low while break send");
    a_err_empty: assert property (rx_fifo_level == 7'h0 && $past(rx_fifo_level) == 7'h0
        |-> line_status_reg[4:2] == 3'h0) else $error("error bits set with empty fifo");
    a_sleep_entry: assert property ($rose(sleeping) |-> $past(enhanced_feature_reg[4] && irq_enable_reg[4])
        && $past(rx_fifo_level) == 7'h0) else $error("sleep entered without permission");
    a_sleep_clk: assert property (sleeping |-> !uart_clk_en) else $error("clock runs in sleep");
    a_wake_write: assert property (sleeping && tx_write |=> !sleeping)
        else $error("no wake on tx write");
endmodule

bind urisc_ctrl urisc_chk chk_u (.core_clk(core_clk), .srst(srst), .soft_rst(soft_rst),
    .irq_enable_reg(irq_enable_reg), .enhanced_feature_reg(enhanced_feature_reg),
    .rx_fifo_level(rx_fifo_level), .tx_write(tx_write), .irq_ident_reg(irq_ident_reg),
    .line_status_reg(line_status_reg), .line_ctrl_reg(line_ctrl_reg), .tx_fifo_level(tx_fifo_level),
    .irq_n(irq_n), .tx_pin(tx_pin), .rts_n(rts_n), .io_oe(io_oe), .uart_clk_en(uart_clk_en),
    .sleeping(sleeping));

//--- urisc_host_mdl.sv
// host model that services the interrupt line by reading the ident register
`timescale 1ns/1ps
module urisc_host_mdl #(
    parameter int LAT = 2
) (
    // clock
    input wire logic core_clk,
    // service enable and interrupt line
    input wire logic serve,
    input wire logic irq_n,
    // ident read pulse
    output logic irq_ident_rd
);
    // slow host: waits LAT cycles before reading, then lets the line settle
    initial begin
        irq_ident_rd = 1'b0;
        forever begin
            @(posedge core_clk);
            if (serve && irq_n === 1'b0) begin
                repeat (LAT) @(posedge core_clk);
                #1 irq_ident_rd = 1'b1;
                @(posedge core_clk);
                #1 irq_ident_rd = 1'b0;
                repeat (2) @(posedge core_clk);
            end
        end
    end
endmodule

//--- tb_top.sv
// self-checking testbench for the housekeeping block
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic core_clk = 1'b0, srst = 1'b1, serve = 1'b0, irq_ident_rd;
    logic soft_rst, line_ctrl_wr, rx_push, rx_pop, rx_trig_hit, rx_stop_centre, rx_line, tx_fifo_empty;
    logic tx_shift_empty, tx_trig_hit, tx_write, tx_data_bit, io_change, stop_char_seen, resume_char_seen;
    logic special_char_seen, rts_cts_rise, irq_n, tx_pin, rts_n, io_oe, uart_clk_en, sleeping;
    logic [7:0] irq_enable_reg, fifo_ctrl_reg, line_ctrl_wdata, enhanced_feature_reg, io_irq_enable_reg;
    logic [7:0] irq_ident_reg, line_status_reg, modem_status_reg, line_ctrl_reg, tx_fifo_level;
    logic [2:0] rx_push_err, rx_head_err;
    logic [6:0] rx_fifo_level;
    logic [3:0] modem_in;
    logic [15:0] char_cycles = 16'h0010; // short character keeps the time-out run brief
    int err_count = 0, n_tests = 0;
    // expected ident code per source, table order
    logic [5:0] codes [7] = '{6'h06, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20};

    always #2 core_clk = ~core_clk;

    urisc_ctrl dut_u (.core_clk, .srst, .soft_rst, .irq_enable_reg, .fifo_ctrl_reg, .line_ctrl_wr,
        .line_ctrl_wdata, .enhanced_feature_reg, .io_irq_enable_reg, .rx_push, .rx_push_err, .rx_pop,
        .rx_head_err, .rx_fifo_level, .rx_trig_hit, .rx_stop_centre, .rx_line, .char_cycles, .tx_fifo_empty,
        .tx_shift_empty, .tx_trig_hit, .tx_write, .tx_data_bit, .modem_in, .io_change, .stop_char_seen,
        .resume_char_seen, .special_char_seen, .rts_cts_rise, .irq_ident_rd, .irq_ident_reg, .line_status_reg,
        .modem_status_reg, .line_ctrl_reg, .tx_fifo_level, .irq_n, .tx_pin, .rts_n, .io_oe, .uart_clk_en,
        .sleeping);
    urisc_host_mdl host_u (.core_clk, .serve, .irq_n, .irq_ident_rd);

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // quiet inputs: line idle, transmitter empty
    task automatic idle();
        {soft_rst, line_ctrl_wr, rx_push, rx_pop, rx_trig_hit, rx_stop_centre, tx_trig_hit, tx_write} = '0;
        {io_change, stop_char_seen, resume_char_seen, special_char_seen, rts_cts_rise, serve} = '0;
        {rx_line, tx_fifo_empty, tx_shift_empty, tx_data_bit} = 4'hf;
        {irq_enable_reg, fifo_ctrl_reg, line_ctrl_wdata, enhanced_feature_reg, io_irq_enable_reg} = '0;
        {rx_push_err, rx_head_err, rx_fifo_level, modem_in} = '0;
    endtask
    task automatic rst();
        idle();
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        step(1);
    endtask
    task automatic rst_vals();
        chk(line_ctrl_reg, 8'h1d);
        chk(irq_ident_reg, 8'h01);
        chk(line_status_reg, 8'h60);
        chk({4'h0, modem_status_reg[3:0]}, 8'h00);
        chk(tx_fifo_level, 8'h40);
        chk({3'h0, irq_n, tx_pin, rts_n, io_oe, uart_clk_en}, 8'h1d);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_soft();
        line_ctrl_wr = 1'b1;
        line_ctrl_wdata = 8'h03;
        step(1);
        line_ctrl_wr = 1'b0;
        step(1);
        chk(line_ctrl_reg, 8'h03);
        soft_rst = 1'b1;
        step(1);
        soft_rst = 1'b0;
        step(1);
        rst_vals();
    endtask
    // one source at a time, each behind its own enable
    task automatic t_codes();
        for (int i = 0; i < 7; i++) begin
            rst();
            case (i)
                0: {irq_enable_reg, rx_push, rx_push_err, rx_fifo_level} = {8'h04, 1'b1, 3'h1, 7'h1};
                1: {irq_enable_reg, fifo_ctrl_reg, rx_trig_hit, rx_fifo_level} = {8'h01, 8'h01, 1'b1, 7'h8};
                2: irq_enable_reg = 8'h02;
                3: {irq_enable_reg, modem_in} = {8'h08, 4'h1};
                4: {io_irq_enable_reg, io_change} = {8'h01, 1'b1};
                5: {irq_enable_reg, stop_char_seen} = {8'h20, 1'b1};
                default: {irq_enable_reg, rts_cts_rise} = {8'h80, 1'b1};
            endcase
            step(1);
            {rx_push, io_change, stop_char_seen, rts_cts_rise} = '0;
            step(3);
            chk(irq_ident_reg[5:0], codes[i]);
            chk(irq_n, 1'b0);
        end
    endtask
    task automatic t_prio();
        rst();
        {irq_enable_reg, io_irq_enable_reg, modem_in} = {8'hed, 8'h01, 4'h2};
        {stop_char_seen, io_change, rts_cts_rise} = 3'h7;
        step(1);
        {stop_char_seen, io_change, rts_cts_rise} = 3'h0;
        step(3);
        chk(irq_ident_reg[5:0], 6'h00);
        chk(modem_status_reg, 8'hd2);
        {rx_push, rx_push_err, rx_fifo_level} = {1'b1, 3'h2, 7'h1};
        step(1);
        rx_push = 1'b0;
        step(3);
        chk(irq_ident_reg[5:0], 6'h06);
    endtask
    task automatic t_xoff();
        rst();
        {irq_enable_reg, stop_char_seen} = {8'h20, 1'b1};
        step(1);
        stop_char_seen = 1'b0;
        step(3);
        resume_char_seen = 1'b1;
        step(1);
        resume_char_seen = 1'b0;
        step(3);
        chk({irq_n, irq_ident_reg[5:0]}, 8'h41);
        {special_char_seen, serve} = 2'h3;
        step(1);
        special_char_seen = 1'b0;
        step(2);
        chk(irq_ident_reg[5:0], 6'h10);
        step(10);
        chk({irq_n, irq_ident_reg[5:0]}, 8'h41);
    endtask
    task automatic t_polled();
        rst();
        {fifo_ctrl_reg, rx_trig_hit, rx_fifo_level} = {8'h01, 1'b1, 7'h8};
        step(4);
        chk({irq_n, irq_ident_reg[5:0]}, 8'h41);
    endtask
    task automatic t_timeout();
        rst();
        {irq_enable_reg, fifo_ctrl_reg, rx_push, rx_fifo_level} = {8'h01, 8'h01, 1'b1, 7'h1};
        step(1);
        {rx_push, rx_stop_centre} = 2'h1;
        step(1);
        rx_stop_centre = 1'b0;
        step(4 * 16 - 8);
        chk(irq_ident_reg[5:0], 6'h01);
        step(14);
        chk({irq_n, irq_ident_reg[5:0]}, 8'h0c);
    endtask
    task automatic t_errs();
        rst();
        {irq_enable_reg, fifo_ctrl_reg, rx_push, rx_push_err, rx_head_err, rx_fifo_level} =
            {8'h04, 8'h01, 1'b1, 3'h4, 3'h4, 7'h1};
        step(1);
        {rx_push_err, rx_fifo_level} = {3'h0, 7'h2};
        step(1);
        rx_push = 1'b0;
        step(2);
        chk({line_status_reg[7], line_status_reg[4:2]}, 8'hc);
        rx_pop = 1'b1;
        step(1);
        {rx_pop, rx_head_err, rx_fifo_level} = {1'b0, 3'h0, 7'h1};
        step(2);
        chk({line_status_reg[7], line_status_reg[4:2]}, 8'h0);
    endtask
    task automatic t_break();
        rst();
        {line_ctrl_wr, line_ctrl_wdata} = {1'b1, 8'h40};
        step(1);
        line_ctrl_wr = 1'b0;
        step(2);
        chk(tx_pin, 1'b0);
        {line_ctrl_wr, line_ctrl_wdata} = {1'b1, 8'h00};
        step(1);
        line_ctrl_wr = 1'b0;
        step(2);
        chk(tx_pin, 1'b1);
        // line low one character plus three cycles before break shows
        {rx_fifo_level, rx_line} = {7'h1, 1'b0};
        step(17);
        chk(line_status_reg[4], 1'b0);
        step(2);
        chk(line_status_reg[4], 1'b1);
        rx_line = 1'b1;
        step(2);
        chk(line_status_reg[4], 1'b0);
    endtask
    task automatic t_sleep();
        rst();
        {irq_enable_reg, modem_in} = {8'h1a, 4'h1};
        step(4);
        chk(sleeping, 1'b0);
        {enhanced_feature_reg, rx_fifo_level} = {8'h10, 7'h1};
        step(4);
        chk(sleeping, 1'b0);
        // modem change pends behind transmit-empty
        rx_fifo_level = 7'h0;
        step(4);
        chk(sleeping, 1'b0);
        rst();
        {irq_enable_reg, enhanced_feature_reg} = {8'h12, 8'h10};
        step(4);
        chk({sleeping, uart_clk_en}, 8'h2);
        tx_write = 1'b1;
        step(1);
        tx_write = 1'b0;
        chk(sleeping, 1'b0);
        step(2);
        chk(sleeping, 1'b1);
        rx_line = 1'b0;
        step(1);
        chk(sleeping, 1'b0);
    endtask

    // ----------------------------------------
    // verdict, main sequence and watchdog
    // ----------------------------------------
    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        idle();
        step(16);
        srst = 1'b0;
        step(1);
        rst_vals();
        t_soft();
        t_codes();
        t_prio();
        t_xoff();
        t_polled();
        t_timeout();
        t_errs();
        t_break();
        t_sleep();
        results();
    end
    // whole run is well under a thousand cycles
    initial begin
        #40000;
        err_count++;
        results();
    end
endmodule
